// ### hw/xsa_pkg.sv
// constants and types for the exchange / stack / add datapath
// assumes a single 100 MHz core clock and a byte-wide data memory port
package xsa_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0]  WREG_RST = 8'h00;
   localparam logic [7:0]  FLAG_RST = 8'h00;
   localparam logic [7:0]  SP_RST   = 8'h00;
   localparam logic [7:0]  SP_STEP  = 8'h02;
   localparam logic [7:0]  SP_HI    = 8'h01;
   // flag byte bit positions
   localparam int unsigned FZ_BIT  = 0;
   localparam int unsigned FC_BIT  = 1;
   localparam int unsigned FAC_BIT = 2;
   localparam int unsigned FOV_BIT = 3;
   // operation codes on the request port
   localparam logic [3:0] OP_SWAP  = 4'h1;
   localparam logic [3:0] OP_PUSH  = 4'h2;
   localparam logic [3:0] OP_POP   = 4'h3;
   localparam logic [3:0] OP_ADDI  = 4'h4;
   localparam logic [3:0] OP_ADDAM = 4'h5;
   localparam logic [3:0] OP_ADDMA = 4'h6;
   localparam logic [3:0] OP_ADCAM = 4'h7;
   localparam logic [3:0] OP_ADCMA = 4'h8;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RD, ST_RD2, ST_EXEC, ST_WR2, ST_DONE
   } state_t;
endpackage : xsa_pkg

// ### hw/alu_if.sv
// adder operand/result bundle between datapath and adder
// assumes both ends in the same clock domain
interface alu_if;
   logic [7:0] op_a;
   logic [7:0] op_b;
   logic       cin;
   logic [7:0] sum;
   logic [3:0] flags;
   modport core (output op_a, output op_b, output cin,
                 input sum, input flags);
   modport adder (input op_a, input op_b, input cin,
                  output sum, output flags);
endinterface : alu_if

// ### hw/byte_adder.sv
// 8-bit adder with zero, carry, nibble carry and signed range flags
// assumes flag positions from xsa_pkg
module byte_adder (
   alu_if.adder a
);
   import xsa_pkg::*;
   logic [4:0] lo;
   logic [8:0] full;
   logic [7:0] s;
   always_comb begin
      lo   = {1'b0, a.op_a[3:0]} + {1'b0, a.op_b[3:0]} + {4'h0, a.cin};
      full = {1'b0, a.op_a} + {1'b0, a.op_b} + {8'h00, a.cin};
      s    = full[7:0];
      a.sum = s;
      a.flags[FZ_BIT]  = (s == 8'h00);
      a.flags[FC_BIT]  = full[8];
      a.flags[FAC_BIT] = lo[4];
      a.flags[FOV_BIT] = (a.op_a[7] == a.op_b[7])
                         && (s[7] != a.op_a[7]);
   end
endmodule : byte_adder

// ### hw/xsa_datapath.sv
// exchange, stack and add datapath for the 8-bit core
// assumes memory reads return data the cycle after mem_rd
module xsa_datapath (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // operation request
   input  wire logic             op_valid,
   input  wire logic [3:0]       op_code,
   input  wire logic [7:0]       op_addr,
   input  wire logic [7:0]       op_imm,
   // data memory
   output logic                  mem_rd,
   output logic                  mem_wr,
   output logic [7:0]            mem_addr,
   output logic [7:0]            mem_wdata,
   input  wire logic [7:0]       mem_rdata,
   // state
   output logic                  busy,
   output logic                  done,
   output logic [7:0]            working_register,
   output logic [3:0]            flags,
   output logic [7:0]            stack_pointer
);
   import xsa_pkg::*;

   state_t     st_ff, nxt_st;
   logic [3:0] op_ff;
   logic [7:0] addr_ff;
   logic [7:0] imm_ff;
   logic [7:0] wreg_ff;
   logic [3:0] flag_ff;
   logic [7:0] sp_ff;
   logic       rd_ff, wr_ff, done_ff, busy_ff;
   logic [7:0] maddr_ff, wdata_ff;
   logic       uses_mem;
   alu_if      alu ();

   byte_adder u_add (.a(alu.adder));

   assign uses_mem = (op_code != OP_ADDI) && (op_code != OP_PUSH);

   // adder operands
   always_comb begin
      alu.op_a = wreg_ff;
      // memory byte is taken off the read port in its data cycle
      alu.op_b = (op_ff == OP_ADDI) ? imm_ff : mem_rdata;
      alu.cin  = ((op_ff == OP_ADCAM) || (op_ff == OP_ADCMA))
                 ? flag_ff[FC_BIT] : 1'b0;
   end

   // sequencing
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: begin
            if (op_valid) begin
               if (uses_mem) begin
                  nxt_st = ST_RD;
               end else begin
                  nxt_st = ST_EXEC;
               end
            end
         end
         ST_RD: begin
            if (op_ff == OP_POP) begin
               nxt_st = ST_RD2;
            end else begin
               nxt_st = ST_EXEC;
            end
         end
         ST_RD2: nxt_st = ST_EXEC;
         ST_EXEC: begin
            if (op_ff == OP_PUSH) begin
               nxt_st = ST_WR2;
            end else begin
               nxt_st = ST_DONE;
            end
         end
         ST_WR2: nxt_st = ST_DONE;
         ST_DONE: nxt_st = ST_IDLE;
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // request capture
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_ff   <= 4'h0;
         addr_ff <= 8'h00;
         imm_ff  <= 8'h00;
      end else if (st_ff == ST_IDLE && op_valid) begin
         op_ff   <= op_code;
         addr_ff <= op_addr;
         imm_ff  <= op_imm;
      end
   end

   // busy level, registered from the next state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_st != ST_IDLE);
      end
   end

   // stack pointer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_ff <= SP_RST;
      end else if (st_ff == ST_WR2) begin
         sp_ff <= sp_ff + SP_STEP;
      end else if (st_ff == ST_IDLE && op_valid
                   && op_code == OP_POP) begin
         sp_ff <= sp_ff - SP_STEP;
      end
   end

   // working register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wreg_ff <= WREG_RST;
      end else if (st_ff == ST_RD2) begin
         wreg_ff <= mem_rdata;
      end else if (st_ff == ST_EXEC) begin
         case (op_ff)
            OP_SWAP: wreg_ff <= mem_rdata;
            OP_ADDI, OP_ADDAM, OP_ADCAM: begin
               wreg_ff <= alu.sum;
            end
            default: wreg_ff <= wreg_ff;
         endcase
      end
   end

   // flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= FLAG_RST[3:0];
      end else if (st_ff == ST_EXEC) begin
         case (op_ff)
            OP_POP: flag_ff <= mem_rdata[3:0];
            OP_ADDI, OP_ADDAM, OP_ADDMA, OP_ADCAM, OP_ADCMA: begin
               flag_ff <= alu.flags;
            end
            default: flag_ff <= flag_ff;
         endcase
      end
   end

   // memory port
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_ff    <= 1'b0;
         wr_ff    <= 1'b0;
         maddr_ff <= 8'h00;
         wdata_ff <= 8'h00;
      end else begin
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         if (st_ff == ST_IDLE && op_valid && uses_mem) begin
            rd_ff <= 1'b1;
            if (op_code == OP_POP) begin
               maddr_ff <= sp_ff - SP_STEP;
            end else begin
               maddr_ff <= op_addr;
            end
         end else if (st_ff == ST_RD && op_ff == OP_POP) begin
            rd_ff    <= 1'b1;
            maddr_ff <= sp_ff + SP_HI;
         end else if (st_ff == ST_EXEC) begin
            case (op_ff)
               OP_SWAP: begin
                  wr_ff    <= 1'b1;
                  maddr_ff <= addr_ff;
                  wdata_ff <= wreg_ff;
               end
               OP_ADDMA, OP_ADCMA: begin
                  wr_ff    <= 1'b1;
                  maddr_ff <= addr_ff;
                  wdata_ff <= alu.sum;
               end
               OP_PUSH: begin
                  wr_ff    <= 1'b1;
                  maddr_ff <= sp_ff;
                  wdata_ff <= wreg_ff;
               end
               default: wr_ff <= 1'b0;
            endcase
         end else if (st_ff == ST_WR2) begin
            wr_ff    <= 1'b1;
            maddr_ff <= sp_ff + SP_HI;
            wdata_ff <= {4'h0, flag_ff};
         end
      end
   end

   // completion pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= (st_ff == ST_DONE);
      end
   end

   assign mem_rd           = rd_ff;
   assign mem_wr           = wr_ff;
   assign mem_addr         = maddr_ff;
   assign mem_wdata        = wdata_ff;
   assign busy             = busy_ff;
   assign done             = done_ff;
   assign working_register = wreg_ff;
   assign flags            = flag_ff;
   assign stack_pointer    = sp_ff;
endmodule : xsa_datapath

// ### testbench/xsa_datapath_assertions.sv
// port-level assertions for the exchange, stack and add datapath
// assumes one clock domain with asynchronous active-low reset
module xsa_checker
   import xsa_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       op_valid,
   input wire logic [3:0] op_code,
   input wire logic [7:0] op_imm,
   input wire logic       mem_rd,
   input wire logic       mem_wr,
   input wire logic [7:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic       busy,
   input wire logic       done,
   input wire logic [7:0] working_register,
   input wire logic [3:0] flags,
   input wire logic [7:0] stack_pointer
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire take = op_valid && !busy;
   wire addi = take && op_code == OP_ADDI;
   wire push = take && op_code == OP_PUSH;
   wire pop  = take && op_code == OP_POP;
   AST_PUSH_WREG: assert property (push |-> ##2 mem_wr &&
      mem_addr == $past(stack_pointer, 2) &&
      mem_wdata == $past(working_register, 2)) else $error("push byte");
   AST_PUSH_FLAG: assert property (push |-> ##3 mem_wr &&
      mem_addr == $past(stack_pointer, 3) + 8'h01 &&
      mem_wdata == {4'h0, $past(flags, 3)}) else $error("push flags");
   AST_PUSH_SP: assert property (push |-> ##4 done &&
      stack_pointer == $past(stack_pointer, 4) + SP_STEP)
      else $error("push pointer");
   AST_POP_SP: assert property (pop |=> mem_rd &&
      stack_pointer == $past(stack_pointer) - SP_STEP &&
      mem_addr == stack_pointer) else $error("pop pointer");
   AST_SWAP_FLAGS: assert property (take && op_code == OP_SWAP |->
      ##4 done && flags == $past(flags, 4)) else $error("swap flags");
   AST_ADDI_SUM: assert property (addi |-> ##3 done &&
      working_register == $past(working_register, 3) + $past(op_imm, 3))
      else $error("addi sum");
   AST_ADDI_ZERO: assert property (addi |->
      ##3 flags[FZ_BIT] == (working_register == 8'h00)) else $error("zero");
   AST_ADDI_CARRY: assert property (addi |-> ##3 flags[FC_BIT] ==
      (9'($past(working_register, 3)) + 9'($past(op_imm, 3)) > 9'h0ff))
      else $error("carry");
   AST_ADDMA_KEEP: assert property (take && op_code == OP_ADDMA |->
      ##4 done && working_register == $past(working_register, 4))
      else $error("add to memory");
   AST_BUSY_SPAN: assert property (take |=> busy ##1 busy)
      else $error("busy low during an operation");
   cover property (push);
   cover property (pop);
   cover property (take && op_code == OP_ADCAM);
endmodule : xsa_checker

bind xsa_datapath xsa_checker chk_u (.clk, .rst_n, .op_valid, .op_code,
   .op_imm, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .busy, .done,
   .working_register, .flags, .stack_pointer);

// ### testbench/xsa_datapath_tb.sv
// self-checking bench: drives operations and plays the data memory
// assumes the xsa_pkg encodings and a 100 MHz core clock
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
   $display("Error %0t: result mismatch", $time); end end
module xsa_datapath_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import xsa_pkg::*;
   typedef struct packed {
      logic [3:0] f;
      logic [7:0] w, s, a1, v1, a2, v2;
   } note_t;
   logic       clk, rst_n, op_valid, mem_rd, mem_wr, busy, done;
   logic [3:0] op_code, flags, m_f;
   logic [7:0] op_addr, op_imm, mem_addr, mem_wdata, mem_rdata;
   logic [7:0] working_register, stack_pointer, m_w, m_s;
   logic [7:0] mem [256];
   note_t      q[$];
   note_t      n;
   int         num_errors, check_count;
   xsa_datapath dut_u (.clk, .rst_n, .op_valid, .op_code, .op_addr, .op_imm,
      .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .busy, .done,
      .working_register, .flags, .stack_pointer);
   always #5 clk = ~clk;
   // memory: data the cycle after a read, scrambled otherwise
   always @(posedge clk) begin
      if (mem_wr) mem[mem_addr] <= mem_wdata;
      mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
      if (done === 1'b1) begin
         n = q.pop_front();
         `CHK(working_register, n.w)
         `CHK(flags, n.f)
         `CHK(stack_pointer, n.s)
         `CHK(mem[n.a1], n.v1)
         `CHK(mem[n.a2], n.v2)
         `CHK(busy, 1'b0)
      end
   end
   function automatic logic [11:0] add8(logic [7:0] a, b, logic c);
      logic [8:0] s;
      s = a + b + c;
      return {(a[7] == b[7]) && (s[7] != a[7]), (a[3:0] + b[3:0] + c) > 5'd15,
              s[8], s[7:0] == 8'h00, s[7:0]};
   endfunction : add8
   task automatic do_op(logic [3:0] c, logic [7:0] a, i);
      logic [11:0] r;
      note_t       e;
      e = '{m_f, m_w, m_s, a, mem[a], a, mem[a]};
      r = add8(m_w, c == OP_ADDI ? i : mem[a],
               (c == OP_ADCAM || c == OP_ADCMA) && m_f[FC_BIT]);
      case (c)
         OP_SWAP: {e.w, e.v1, e.v2} = {mem[a], m_w, m_w};
         OP_PUSH: begin
            {e.a1, e.v1, e.a2} = {m_s, m_w, m_s + 8'h01};
            {e.v2, e.s} = {4'h0, m_f, m_s + 8'h02};
         end
         OP_POP: begin
            e.s = m_s - 8'h02;
            {e.w, e.f} = {mem[e.s], mem[e.s + 8'h01][3:0]};
         end
         OP_ADDI, OP_ADDAM, OP_ADCAM: {e.f, e.w} = r;
         default: {e.f, e.v1, e.v2} = {r[11:8], r[7:0], r[7:0]};
      endcase
      {m_f, m_w, m_s} = {e.f, e.w, e.s};
      q.push_back(e);
      {op_valid, op_code, op_addr, op_imm} <= {1'b1, c, a, i};
      @(posedge clk) op_valid <= 1'b0;
      for (int k = 0; k < 20 && done !== 1'b1; k++) @(negedge clk);
      `CHK(done, 1'b1)
      @(posedge clk);
   endtask : do_op
   task final_report;
      if (num_errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report
   initial begin
      #100us;
      num_errors++;
      final_report();
   end
   initial begin
      {clk, rst_n, op_valid, op_code, op_addr, op_imm, mem_rdata} = '0;
      {m_w, m_f, m_s} = '0;
      void'($urandom(80547));
      foreach (mem[j]) mem[j] = 8'($urandom);
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      // signed overflow, nibble carry, zero and carry edges
      do_op(OP_ADDI, 8'h00, 8'h7f);
      do_op(OP_ADDI, 8'h00, 8'h01);
      do_op(OP_ADDI, 8'h00, 8'h80);
      do_op(OP_PUSH, 8'h00, 8'h00);
      do_op(OP_ADDI, 8'h00, 8'h05);
      do_op(OP_POP, 8'h00, 8'h00);
      for (int k = 0; k < 80; k++)
         do_op(4'($urandom_range(1, 8)), 8'($urandom), 8'($urandom));
      final_report();
   end
endmodule : xsa_datapath_tb
